// ---- verilog/ecc_pkg.sv ----
// Constants and code matrix of the SDRAM check-byte unit
// How it works
// - Every data and check bit has own code
// - Data codes fixed, three or five ones
// - Check byte is XOR of set-bit codes
// - Full checked writes carry fresh check byte along
// - Narrow checked writes become read-modify-write
// - Syndrome is calculated XOR stored check byte
// - Zero syndrome passes data unchanged
// - Single-one syndrome ignored, no report
// - Matching data code flips that bit
// - Other syndromes flagged, data left untouched
// - Bypass path gets no checking
// - Data error sets cause flag, interrupt unless cause_mask
// - Raw word captured in two halves
// - Stored and calculated bytes captured
// - Report single versus multiple error
// - Check byte lines carry check byte
package ecc_pkg;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int DATA_W = 64;
	localparam int CHK_W = 8;
	localparam int BE_W = 8;

	// ------------------------------------------------------------
	// Values
	// ------------------------------------------------------------
	// Byte enables of a whole word
	localparam logic [7:0] BE_FULL = 8'hff;
	// Syndrome of a clean word
	localparam logic [7:0] SYN_CLEAN = 8'h00;
	// Weights of syndromes
	localparam int ONES_CHECK = 1;
	localparam int ONES_DATA_A = 3;
	localparam int ONES_DATA_B = 5;

	// ------------------------------------------------------------
	// Code matrix, index is the data bit
	// ------------------------------------------------------------
	// data bit codes
	localparam logic [7:0] DATA_CODE [DATA_W] = '{
		8'h13, 8'h23, 8'h43, 8'h83, 8'h2f, 8'hf1, 8'h0d, 8'h07,
		8'hd0, 8'h70, 8'h4f, 8'hf8, 8'h61, 8'h62, 8'h64, 8'h68,
		8'h1c, 8'h2c, 8'h4c, 8'h8c, 8'h15, 8'h25, 8'h45, 8'h85,
		8'h19, 8'h29, 8'h49, 8'h89, 8'h1a, 8'h2a, 8'h4a, 8'h8a,
		8'h51, 8'h52, 8'h54, 8'h58, 8'h91, 8'h92, 8'h94, 8'h98,
		8'ha1, 8'ha2, 8'ha4, 8'ha8, 8'h31, 8'h32, 8'h34, 8'h38,
		8'h16, 8'h26, 8'h46, 8'h86, 8'h1f, 8'hf2, 8'h0b, 8'h0e,
		8'hb0, 8'he0, 8'h8f, 8'hf4, 8'hc1, 8'hc2, 8'hc4, 8'hc8
	};

endpackage : ecc_pkg

// ---- verilog/sdram_secded_ecc_unit.sv ----
// Check-byte generation, syndrome decode and error report for 64-bit SDRAM
module sdram_secded_ecc_unit #(
	parameter int ADDR_W = 26
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic ecc_enable,
	input wire logic bypass_path,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_write,
	input wire logic [ADDR_W-1:0] req_addr,
	input wire logic [ecc_pkg::DATA_W-1:0] req_wdata,
	input wire logic [ecc_pkg::BE_W-1:0] req_be,
	output logic rsp_valid,
	output logic [ecc_pkg::DATA_W-1:0] rsp_rdata,
	output logic rsp_corrected,
	output logic rsp_uncorrectable,
	output logic mem_req,
	output logic mem_we,
	output logic [ADDR_W-1:0] mem_addr,
	output logic [ecc_pkg::DATA_W-1:0] mem_wdata,
	output logic [ecc_pkg::BE_W-1:0] mem_be,
	input wire logic mem_rvalid,
	input wire logic [ecc_pkg::DATA_W-1:0] mem_rdata,
	output logic [ecc_pkg::CHK_W-1:0] check_byte_lines_o,
	output logic check_byte_lines_oe,
	input wire logic [ecc_pkg::CHK_W-1:0] check_byte_lines_i,
	input wire logic cause_clear,
	input wire logic cause_mask,
	output logic memory_error_cause_flag,
	output logic irq,
	output logic [31:0] report_data_hi,
	output logic [31:0] report_data_lo,
	output logic [ecc_pkg::CHK_W-1:0] report_check_mem,
	output logic [ecc_pkg::CHK_W-1:0] report_check_calc,
	output logic report_multi
);

	// ------------------------------------------------------------
	// Types and functions
	// ------------------------------------------------------------
	typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_RMW} state_e;

	// Check byte of a word
	function automatic logic [ecc_pkg::CHK_W-1:0] gen_check(input logic [ecc_pkg::DATA_W-1:0] d);
		logic [ecc_pkg::CHK_W-1:0] c;
		c = '0;
		for (int i = 0; i < ecc_pkg::DATA_W; i++) begin
			if (d[i]) begin
				c = c ^ ecc_pkg::DATA_CODE[i];
			end
		end
		return c;
	endfunction : gen_check

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	state_e state_ff, nxt_state;
	logic mem_req_ff, nxt_mem_req;
	logic mem_we_ff, nxt_mem_we;
	logic [ADDR_W-1:0] mem_addr_ff, nxt_mem_addr;
	logic [ecc_pkg::DATA_W-1:0] mem_wdata_ff, nxt_mem_wdata;
	logic [ecc_pkg::BE_W-1:0] mem_be_ff, nxt_mem_be;
	logic [ecc_pkg::CHK_W-1:0] chk_out_ff, nxt_chk_out;
	logic chk_oe_ff, nxt_chk_oe;
	// Pending write data and enables of a merge
	logic [ecc_pkg::DATA_W-1:0] wdata_ff, nxt_wdata;
	logic [ecc_pkg::BE_W-1:0] be_ff, nxt_be;
	// Checking applies to the current transfer
	logic ecc_act_ff, nxt_ecc_act;
	logic rsp_valid_ff, nxt_rsp_valid;
	logic [ecc_pkg::DATA_W-1:0] rsp_data_ff, nxt_rsp_data;
	logic rsp_corr_ff, nxt_rsp_corr;
	logic rsp_unc_ff, nxt_rsp_unc;
	// Report group
	logic flag_ff, nxt_flag;
	logic [ecc_pkg::DATA_W-1:0] rep_data_ff, nxt_rep_data;
	logic [ecc_pkg::CHK_W-1:0] rep_mem_ff, nxt_rep_mem;
	logic [ecc_pkg::CHK_W-1:0] rep_calc_ff, nxt_rep_calc;
	logic rep_multi_ff, nxt_rep_multi;

	// ------------------------------------------------------------
	// Read decode
	// ------------------------------------------------------------
	logic [ecc_pkg::CHK_W-1:0] calc_chk;
	logic [ecc_pkg::CHK_W-1:0] syndrome;
	int syn_ones;
	logic [ecc_pkg::DATA_W-1:0] fix_mask;
	logic [ecc_pkg::DATA_W-1:0] corr_data;
	logic [ecc_pkg::DATA_W-1:0] merged;
	logic data_err;
	logic single_err;
	logic req_ecc;
	logic capture;

	// Syndrome, correction mask and merge of a narrow write
	always_comb begin
		calc_chk = gen_check(mem_rdata);
		syndrome = calc_chk ^ check_byte_lines_i;
		syn_ones = $countones(syndrome);
		for (int i = 0; i < ecc_pkg::DATA_W; i++) begin
			fix_mask[i] = (syndrome == ecc_pkg::DATA_CODE[i])
				&& (syn_ones == ecc_pkg::ONES_DATA_A || syn_ones == ecc_pkg::ONES_DATA_B);
		end
		corr_data = mem_rdata ^ fix_mask;
		single_err = |fix_mask;
		data_err = (syndrome != ecc_pkg::SYN_CLEAN) && (syn_ones != ecc_pkg::ONES_CHECK);
		for (int b = 0; b < ecc_pkg::BE_W; b++) begin
			merged[b*8 +: 8] = be_ff[b] ? wdata_ff[b*8 +: 8] : corr_data[b*8 +: 8];
		end
	end

	assign req_ecc = ecc_enable && !bypass_path;
	assign capture = mem_rvalid && ecc_act_ff && data_err && (state_ff != ST_IDLE);

	// ------------------------------------------------------------
	// Transfer sequencer
	// ------------------------------------------------------------
	// Next values of the sequencer and memory side
	always_comb begin
		nxt_state = state_ff;
		nxt_mem_req = 1'b0;
		nxt_mem_we = mem_we_ff;
		nxt_mem_addr = mem_addr_ff;
		nxt_mem_wdata = mem_wdata_ff;
		nxt_mem_be = mem_be_ff;
		nxt_chk_out = chk_out_ff;
		nxt_chk_oe = 1'b0;
		nxt_wdata = wdata_ff;
		nxt_be = be_ff;
		nxt_ecc_act = ecc_act_ff;
		nxt_rsp_valid = 1'b0;
		nxt_rsp_data = rsp_data_ff;
		nxt_rsp_corr = 1'b0;
		nxt_rsp_unc = 1'b0;
		case (state_ff)
			ST_IDLE: begin
				// New request from the controller core
				if (req_valid) begin
					nxt_mem_req = 1'b1;
					nxt_mem_addr = req_addr;
					nxt_wdata = req_wdata;
					nxt_be = req_be;
					nxt_ecc_act = req_ecc;
					if (req_write && (req_be == ecc_pkg::BE_FULL || !req_ecc)) begin
						nxt_mem_we = 1'b1;
						nxt_mem_wdata = req_wdata;
						nxt_mem_be = req_be;
						nxt_chk_out = gen_check(req_wdata);
						nxt_chk_oe = req_ecc;
					end else if (req_write) begin
						nxt_mem_we = 1'b0;
						nxt_mem_be = ecc_pkg::BE_FULL;
						nxt_state = ST_RMW;
					end else begin
						// Plain read
						nxt_mem_we = 1'b0;
						nxt_mem_be = ecc_pkg::BE_FULL;
						nxt_state = ST_READ;
					end
				end
			end
			ST_READ: begin
				// Forward word once memory answers
				if (mem_rvalid) begin
					nxt_rsp_valid = 1'b1;
					nxt_rsp_data = ecc_act_ff ? corr_data : mem_rdata;
					nxt_rsp_corr = ecc_act_ff && single_err;
					nxt_rsp_unc = ecc_act_ff && data_err && !single_err;
					nxt_state = ST_IDLE;
				end
			end
			ST_RMW: begin
				// Write back merged word with fresh check byte
				if (mem_rvalid) begin
					nxt_mem_req = 1'b1;
					nxt_mem_we = 1'b1;
					nxt_mem_wdata = merged;
					nxt_mem_be = ecc_pkg::BE_FULL;
					nxt_chk_out = gen_check(merged);
					nxt_chk_oe = 1'b1;
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// Registers of the sequencer
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state_ff <= ST_IDLE;
			mem_req_ff <= 1'b0;
			mem_we_ff <= 1'b0;
			mem_addr_ff <= '0;
			mem_wdata_ff <= '0;
			mem_be_ff <= '0;
			chk_out_ff <= '0;
			chk_oe_ff <= 1'b0;
			wdata_ff <= '0;
			be_ff <= '0;
			ecc_act_ff <= 1'b0;
			rsp_valid_ff <= 1'b0;
			rsp_data_ff <= '0;
			rsp_corr_ff <= 1'b0;
			rsp_unc_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			mem_req_ff <= nxt_mem_req;
			mem_we_ff <= nxt_mem_we;
			mem_addr_ff <= nxt_mem_addr;
			mem_wdata_ff <= nxt_mem_wdata;
			mem_be_ff <= nxt_mem_be;
			chk_out_ff <= nxt_chk_out;
			chk_oe_ff <= nxt_chk_oe;
			wdata_ff <= nxt_wdata;
			be_ff <= nxt_be;
			ecc_act_ff <= nxt_ecc_act;
			rsp_valid_ff <= nxt_rsp_valid;
			rsp_data_ff <= nxt_rsp_data;
			rsp_corr_ff <= nxt_rsp_corr;
			rsp_unc_ff <= nxt_rsp_unc;
		end
	end

	// ------------------------------------------------------------
	// Error report
	// ------------------------------------------------------------
	// Next values of cause flag and report words
	always_comb begin
		nxt_flag = (flag_ff && !cause_clear) || capture;
		nxt_rep_data = rep_data_ff;
		nxt_rep_mem = rep_mem_ff;
		nxt_rep_calc = rep_calc_ff;
		nxt_rep_multi = rep_multi_ff;
		if (capture) begin
			nxt_rep_data = mem_rdata;
			nxt_rep_mem = check_byte_lines_i;
			nxt_rep_calc = calc_chk;
			nxt_rep_multi = !single_err;
		end
	end

	// Registers of the report
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			flag_ff <= 1'b0;
			rep_data_ff <= '0;
			rep_mem_ff <= '0;
			rep_calc_ff <= '0;
			rep_multi_ff <= 1'b0;
		end else begin
			flag_ff <= nxt_flag;
			rep_data_ff <= nxt_rep_data;
			rep_mem_ff <= nxt_rep_mem;
			rep_calc_ff <= nxt_rep_calc;
			rep_multi_ff <= nxt_rep_multi;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign req_ready = (state_ff == ST_IDLE);
	assign rsp_valid = rsp_valid_ff;
	assign rsp_rdata = rsp_data_ff;
	assign rsp_corrected = rsp_corr_ff;
	assign rsp_uncorrectable = rsp_unc_ff;
	assign mem_req = mem_req_ff;
	assign mem_we = mem_we_ff;
	assign mem_addr = mem_addr_ff;
	assign mem_wdata = mem_wdata_ff;
	assign mem_be = mem_be_ff;
	assign check_byte_lines_o = chk_out_ff;
	assign check_byte_lines_oe = chk_oe_ff;
	assign memory_error_cause_flag = flag_ff;
	assign irq = flag_ff && !cause_mask;
	assign report_data_hi = rep_data_ff[63:32];
	assign report_data_lo = rep_data_ff[31:0];
	assign report_check_mem = rep_mem_ff;
	assign report_check_calc = rep_calc_ff;
	assign report_multi = rep_multi_ff;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	property p_wr_check;
		mem_req && mem_we && check_byte_lines_oe |-> check_byte_lines_o == gen_check(mem_wdata);
	endproperty
	a_wr_check: assert property (p_wr_check) else $error("check byte differs from write data");

	property p_rmw_start;
		req_ready && req_valid && req_write && req_ecc && req_be != ecc_pkg::BE_FULL
			|=> mem_req && !mem_we ##1 !mem_req;
	endproperty
	a_rmw_start: assert property (p_rmw_start) else $error("narrow write did not start a read");

	property p_clean;
		state_ff == ST_READ && mem_rvalid && syndrome == ecc_pkg::SYN_CLEAN
			|=> rsp_valid && rsp_rdata == $past(mem_rdata) && !rsp_corrected && !rsp_uncorrectable;
	endproperty
	a_clean: assert property (p_clean) else $error("clean word altered");

	property p_check_only;
		state_ff == ST_READ && mem_rvalid && syn_ones == 1
			|=> rsp_rdata == $past(mem_rdata) && !rsp_uncorrectable && !rsp_corrected;
	endproperty
	a_check_only: assert property (p_check_only) else $error("check byte error acted upon");

	property p_single;
		state_ff == ST_READ && mem_rvalid && ecc_act_ff && single_err
			|=> rsp_corrected && $countones(rsp_rdata ^ $past(mem_rdata)) == 1;
	endproperty
	a_single: assert property (p_single) else $error("single error not corrected");

	property p_multi;
		state_ff == ST_READ && mem_rvalid && ecc_act_ff && data_err && !single_err
			|=> rsp_uncorrectable && rsp_rdata == $past(mem_rdata);
	endproperty
	a_multi: assert property (p_multi) else $error("uncorrectable word mishandled");

	property p_bypass;
		state_ff == ST_READ && mem_rvalid && !ecc_act_ff
			|=> rsp_rdata == $past(mem_rdata) && !rsp_uncorrectable;
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass read was checked");

	property p_flag;
		capture |=> memory_error_cause_flag ##0 (irq == !cause_mask);
	endproperty
	a_flag: assert property (p_flag) else $error("cause flag not raised");

	property p_report;
		capture |=> report_data_hi == $past(mem_rdata[63:32]) && report_data_lo == $past(mem_rdata[31:0])
			&& report_check_calc == $past(calc_chk) && report_multi == !$past(single_err);
	endproperty
	a_report: assert property (p_report) else $error("error report not captured");

endmodule : sdram_secded_ecc_unit

// ---- tb/sdram_bank_model.sv ----
// Behavioural SDRAM data bank with its check-byte bank beside it
module sdram_bank_model (
	input wire logic core_clk,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [25:0] mem_addr,
	input wire logic [63:0] mem_wdata,
	input wire logic [7:0] mem_be,
	input wire logic [7:0] check_byte_lines_o,
	input wire logic check_byte_lines_oe,
	input wire logic [3:0] lat,
	input wire logic [63:0] flip_d,
	input wire logic [7:0] flip_c,
	output logic mem_rvalid,
	output logic [63:0] mem_rdata,
	output logic [7:0] check_byte_lines_i
);
	timeunit 1ns;
	timeprecision 1ps;
	// -----------------------------------------
	// Storage and read pipeline
	// -----------------------------------------
	logic [63:0] data_mem [16]; // Data words
	logic [7:0] chk_mem [16]; // Stored check bytes
	logic [3:0] rd_addr; // Word under read
	int cnt; // Cycles left until read data
	// Clean start, lines idle
	initial begin
		mem_rvalid = 1'b0;
		mem_rdata = 64'h0;
		check_byte_lines_i = 8'h0;
		cnt = 0;
		rd_addr = 4'h0;
		for (int i = 0; i < 16; i++) begin
			data_mem[i] = 64'h0;
			chk_mem[i] = 8'h0;
		end
	end
	// Stores writes, answers reads after lat cycles with the commanded faults
	always @(posedge core_clk) begin
		mem_rvalid <= 1'b0;
		// Lines no longer hold the last value once the answer is gone
		if (mem_rvalid) begin
			mem_rdata <= ~mem_rdata;
			check_byte_lines_i <= ~check_byte_lines_i;
		end
		if (mem_req && mem_we) begin
			for (int b = 0; b < 8; b++) begin
				if (mem_be[b]) begin
					data_mem[mem_addr[3:0]][8*b+:8] <= mem_wdata[8*b+:8];
				end
			end
			if (check_byte_lines_oe) begin
				chk_mem[mem_addr[3:0]] <= check_byte_lines_o;
			end
		end else if (mem_req) begin
			rd_addr <= mem_addr[3:0];
			cnt <= int'(lat);
		end
		if (cnt == 1) begin
			mem_rvalid <= 1'b1;
			mem_rdata <= data_mem[rd_addr] ^ flip_d;
			check_byte_lines_i <= chk_mem[rd_addr] ^ flip_c;
		end
		if (cnt > 0) begin
			cnt <= cnt - 1;
		end
	end
endmodule : sdram_bank_model

// ---- tb/testbench.sv ----
// Self-checking bench of the SDRAM check-byte unit
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	// -----------------------------------------
	// Signals
	// -----------------------------------------
	logic core_clk = 0, rst_n = 0, ecc_enable = 1, bypass_path = 0, req_valid = 0, req_write = 0;
	logic cause_clear = 0, cause_mask = 0;
	logic [25:0] req_addr = 0, mem_addr;
	logic [63:0] req_wdata = 0, flip_d = 0, rsp_rdata, mem_wdata, mem_rdata;
	logic [7:0] req_be = 8'hff, flip_c = 0, mem_be, check_byte_lines_o, check_byte_lines_i;
	logic [7:0] report_check_mem, report_check_calc;
	logic [3:0] lat = 4'h1; // Memory read latency
	logic req_ready, rsp_valid, rsp_corrected, rsp_uncorrectable, mem_req, mem_we, mem_rvalid;
	logic check_byte_lines_oe, memory_error_cause_flag, irq, report_multi;
	logic [31:0] report_data_hi, report_data_lo;
	logic [63:0] shadow [16] = '{default: 64'h0}; // True memory contents
	logic [7:0] shadow_chk [16] = '{default: 8'h0}; // True stored check bytes
	logic [65:0] expq [$]; // Expected read answers
	int fails = 0, num_checks = 0, cycles = 0;
	int bits [5] = '{0, 12, 51, 53, 63};
	logic [63:0] ufl [4] = '{64'h3, 64'h7, 64'hf, 64'hf0000};

	sdram_secded_ecc_unit i_dut (.core_clk, .rst_n, .ecc_enable, .bypass_path, .req_valid, .req_ready,
		.req_write, .req_addr, .req_wdata, .req_be, .rsp_valid, .rsp_rdata, .rsp_corrected, .rsp_uncorrectable,
		.mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_be, .mem_rvalid, .mem_rdata, .check_byte_lines_o,
		.check_byte_lines_oe, .check_byte_lines_i, .cause_clear, .cause_mask, .memory_error_cause_flag, .irq,
		.report_data_hi, .report_data_lo, .report_check_mem, .report_check_calc, .report_multi);
	sdram_bank_model i_mem (.core_clk, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_be, .check_byte_lines_o,
		.check_byte_lines_oe, .lat, .flip_d, .flip_c, .mem_rvalid, .mem_rdata, .check_byte_lines_i);

	// -----------------------------------------
	// Clock, timeout, helpers
	// -----------------------------------------
	initial begin
		forever #5 core_clk = ~core_clk;
	end
	// Cuts a hang short
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			results();
		end
	end
	// Check byte worked out from the code matrix
	function automatic logic [7:0] ecc_of(input logic [63:0] d);
		ecc_of = 8'h00;
		for (int i = 0; i < 64; i++) begin
			if (d[i]) ecc_of ^= ecc_pkg::DATA_CODE[i];
		end
	endfunction : ecc_of
	task automatic chk(input logic [80:0] got, input logic [80:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR time=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task results;
		if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : results
	// One request, held until taken
	task automatic issue(input logic w, input logic [3:0] a, input logic [63:0] d, input logic [7:0] be);
		int n = 0;
		@(posedge core_clk);
		cause_clear <= 1'b0;
		req_valid <= 1'b1;
		req_write <= w;
		req_addr <= 26'(a);
		req_wdata <= d;
		req_be <= be;
		do begin @(negedge core_clk); n++; end while (req_ready !== 1'b1 && n < 50);
		@(posedge core_clk);
		req_valid <= 1'b0;
	endtask : issue
	// Write, then compare what reaches memory
	task automatic wr(input logic [3:0] a, input logic [63:0] d, input logic [7:0] be, input logic ecc);
		logic [63:0] m, exp;
		int n = 0;
		for (int b = 0; b < 8; b++) m[8*b+:8] = {8{be[b]}};
		exp = (shadow[a] & ~m) | (d & m);
		issue(1'b1, a, d, be);
		do begin @(negedge core_clk); n++; end while (!(mem_req === 1'b1 && mem_we === 1'b1) && n < 50);
		chk({mem_wdata, mem_be, check_byte_lines_oe}, {exp, 8'hff, ecc});
		if (ecc) chk(check_byte_lines_o, ecc_of(exp));
		shadow[a] = exp;
		if (ecc) shadow_chk[a] = ecc_of(exp);
	endtask : wr
	// Read with commanded faults, note the answer, then check the report
	task automatic rd(input logic [3:0] a, input logic [63:0] fd, input logic [7:0] fc, input logic c, input logic u);
		logic [63:0] raw;
		int n = 0;
		raw = shadow[a] ^ fd;
		@(posedge core_clk);
		cause_clear <= 1'b1;
		flip_d <= fd;
		flip_c <= fc;
		lat <= 4'($urandom_range(1, 6));
		cause_mask <= 1'($urandom);
		expq.push_back({(c ? shadow[a] : raw), c, u});
		issue(1'b0, a, 64'h0, 8'hff);
		do begin @(negedge core_clk); n++; end while (req_ready !== 1'b1 && n < 50);
		if (c | u) chk({report_data_hi, report_data_lo, report_check_mem, report_check_calc, report_multi},
			{raw, shadow_chk[a] ^ fc, ecc_of(raw), u});
		chk({memory_error_cause_flag, irq}, {c | u, (c | u) & ~cause_mask});
	endtask : rd
	// Compares each read answer against the oldest note
	always @(negedge core_clk) begin
		if (rsp_valid === 1'b1) begin
			if (expq.size() == 0) chk(1, 0);
			else chk({rsp_rdata, rsp_corrected, rsp_uncorrectable}, expq.pop_front());
		end
	end

	// -----------------------------------------
	// Main sequence
	// -----------------------------------------
	initial begin
		void'($urandom(32'hda3a6b52));
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		@(negedge core_clk);
		chk({memory_error_cause_flag, irq, report_multi, rsp_valid, mem_req, req_ready}, 6'b000001);
		// Full writes, clean reads, check-bit-only fault
		wr(4, 64'h45, 8'hff, 1);
		for (int i = 0; i < 4; i++) wr(4'(i), {$urandom, $urandom}, 8'hff, 1);
		for (int i = 0; i < 5; i++) rd(4'(i), 64'h0, 8'h00, 0, 0);
		rd(4, 64'h0, 8'h20, 0, 0);
		// Single data-bit faults, fixed and random positions
		for (int k = 0; k < 8; k++) rd(4'(k % 4), 64'h1 << (k < 5 ? bits[k] : $urandom_range(0, 63)), 8'h00, 1, 0);
		// Multi-bit faults
		rd(0, 64'h20, 8'h01, 0, 1);
		for (int k = 0; k < 4; k++) rd(4'(k), ufl[k], 8'h00, 0, 1);
		// Narrow writes, one over a faulty old word in a byte that is kept
		@(posedge core_clk);
		flip_d <= 64'h0;
		wr(2, {$urandom, $urandom}, 8'h0f, 1);
		@(posedge core_clk);
		flip_d <= 64'h8000;
		wr(3, {$urandom, $urandom}, 8'h81, 1);
		chk({memory_error_cause_flag, report_multi}, 2'b10);
		rd(2, 64'h0, 8'h00, 0, 0);
		rd(3, 64'h0, 8'h00, 0, 0);
		// Bypass path, then checking off
		for (int m = 0; m < 2; m++) begin
			@(posedge core_clk);
			bypass_path <= (m == 0);
			ecc_enable <= (m == 0);
			wr(5, {$urandom, $urandom}, 8'hff, 0);
			rd(0, 64'h200, 8'h00, 0, 0);
		end
		results();
	end
endmodule : testbench
